/* File: rtl/adcsr_fifo.sv */
// Small synchronous FIFO holding finished conversion codes.
// Assumes one clock; push when in_valid and in_ready, pop when out_valid and out_ready.
`timescale 1ns/1ps
module adcsr_fifo #(
    parameter int WIDTH = 12,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    // Pointer wrap relies on a power-of-two depth, so refuse anything else
    if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_params
        $error("adcsr_fifo: DEPTH must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic do_push;
    logic do_pop;
    assign do_push = i_valid && o_ready;
    assign do_pop = o_valid && i_ready;
    assign o_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign o_valid = wr_ptr != rd_ptr;
    assign o_data = mem[rd_ptr[AW-1:0]];
    // Storage writes
    always_ff @(posedge i_clk) begin
        if (do_push) begin
            mem[wr_ptr[AW-1:0]] <= i_data;
        end
    end
    // Pointers; extra bit tells full from empty
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule : adcsr_fifo

/* File: rtl/adcsr_pkg.sv */
// Package for the converter readout block: timing counts and word layout.
// Assumes a 125 MHz core clock; all times are converted to clock cycles here.
package adcsr_pkg;
    localparam int CLK_PERIOD_PS = 8000;
    // Result word layout
    localparam int RESULT_BITS = 12;
    localparam logic [11:0] CODE_POS_FULL = 12'h7ff;
    localparam logic [11:0] CODE_NEG_FULL = 12'h800;
    localparam logic [11:0] RESULT_RESET = 12'h000;
    // Busy low (conversion) typical time, ns, and cycles
    localparam int CONV_TIME_NS = 13500;
    localparam int CONV_CYCLES = (CONV_TIME_NS * 1000) / CLK_PERIOD_PS;
    // Longest busy low, ns
    localparam int CONV_MAX_NS = 15000;
    localparam int CONV_MAX_CYCLES = (CONV_MAX_NS * 1000) / CLK_PERIOD_PS;
    // Previous result readable at least this long after start, ns
    localparam int HOLD_PREV_NS = 12000;
    localparam int HOLD_PREV_CYCLES = (HOLD_PREV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Delay from start to first generated shift clock, ns
    localparam int CLK_START_NS = 204;
    localparam int CLK_START_CYCLES = (CLK_START_NS * 1000) / CLK_PERIOD_PS;
    // Generated shift clock period, typical 820 ns; half period in cycles
    localparam int SCLK_PERIOD_NS = 820;
    localparam int SCLK_HALF_CYCLES = (SCLK_PERIOD_NS * 1000) / (2 * CLK_PERIOD_PS);
    localparam int FIFO_DEPTH = 16;
    typedef enum logic [1:0] {
        ADCSR_IDLE = 2'b00,
        ADCSR_CONV = 2'b01
    } adcsr_conv_t;
endpackage : adcsr_pkg

/* File: rtl/adcsr_readout.sv */
// Conversion control and serial readout with daisy-chain input.
// Assumes i_clk at 125 MHz; convert, select, shift clock and chain input are
// asynchronous pins and are synchronised here. Sample codes arrive from the
// converter core on i_sample with i_over / i_under range flags.
`timescale 1ns/1ps
module adcsr_readout (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_convert_n,
    input wire logic i_chip_select_n,
    input wire logic i_clock_source_select,
    input wire logic i_serial_shift_clock,
    input wire logic i_chain_in,
    input wire logic [11:0] i_sample,
    input wire logic i_over,
    input wire logic i_under,
    output logic o_busy_n,
    output logic o_serial_result_out,
    output logic o_serial_shift_clock,
    output logic o_serial_shift_clock_oe,
    output logic [11:0] o_result,
    output logic o_result_valid,
    input wire logic i_result_ready
);
    localparam int CW = adcsr_pkg::RESULT_BITS;
    // Two-flop synchronisers for all pins
    logic [1:0] cv_s;
    logic [1:0] cs_s;
    logic [1:0] sel_s;
    logic [1:0] sck_s;
    logic [1:0] tag_s;
    logic sck_d;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cv_s <= 2'h3;
            cs_s <= 2'h3;
            sel_s <= 2'h3; // Wake up not driving the clock pin
            sck_s <= 2'h0;
            tag_s <= 2'h0;
            sck_d <= 1'b0;
        end else begin
            cv_s <= {cv_s[0], i_convert_n};
            cs_s <= {cs_s[0], i_chip_select_n};
            sel_s <= {sel_s[0], i_clock_source_select};
            sck_s <= {sck_s[0], i_serial_shift_clock};
            tag_s <= {tag_s[0], i_chain_in};
            sck_d <= sck_s[1];
        end
    end
    logic conv_n;
    logic cs_n;
    logic ext_mode;
    logic ext_rise;
    logic ext_fall;
    logic start;
    assign conv_n = cv_s[1];
    assign cs_n = cs_s[1];
    assign ext_mode = sel_s[1];
    assign ext_rise = sck_s[1] && !sck_d;
    assign ext_fall = !sck_s[1] && sck_d;
    logic start_lvl_d;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            start_lvl_d <= 1'b0;
        end else begin
            start_lvl_d <= !conv_n && !cs_n;
        end
    end
    adcsr_pkg::adcsr_conv_t state;
    assign start = !conv_n && !cs_n && !start_lvl_d && (state == adcsr_pkg::ADCSR_IDLE);
    // clamp out-of-range inputs to full scale
    logic [11:0] clamped;
    always_comb begin
        if (i_over) begin
            clamped = adcsr_pkg::CODE_POS_FULL;
        end else if (i_under) begin
            clamped = adcsr_pkg::CODE_NEG_FULL;
        end else begin
            clamped = i_sample;
        end
    end
    // Conversion timer; the output word is updated only at the end so the
    // previous result stays readable until the end, 1.5 us past the 12 us window
    logic [15:0] conv_cnt;
    logic conv_done;
    assign conv_done = (state == adcsr_pkg::ADCSR_CONV)
        && (conv_cnt == 16'(adcsr_pkg::CONV_CYCLES - 1));
    // busy falls the edge after start is seen
    // busy held low for conversion time
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state <= adcsr_pkg::ADCSR_IDLE;
            conv_cnt <= 16'h0000;
            o_busy_n <= 1'b1;
        end else begin
            case (state)
                adcsr_pkg::ADCSR_IDLE: begin
                    conv_cnt <= 16'h0000;
                    if (start) begin
                        state <= adcsr_pkg::ADCSR_CONV;
                        o_busy_n <= 1'b0;
                    end
                end
                adcsr_pkg::ADCSR_CONV: begin
                    conv_cnt <= conv_cnt + 16'h0001;
                    if (conv_done) begin
                        state <= adcsr_pkg::ADCSR_IDLE;
                        o_busy_n <= 1'b1;
                    end
                end
                default: begin
                    state <= adcsr_pkg::ADCSR_IDLE;
                    o_busy_n <= 1'b1;
                end
            endcase
        end
    end
    // result word held until conversion ends
    logic [11:0] result;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            result <= adcsr_pkg::RESULT_RESET;
        end else if (conv_done) begin
            result <= clamped;
        end
    end
    // Finished codes also go to the parallel stream through the FIFO
    logic fifo_ready;
    logic fifo_valid;
    logic [11:0] fifo_data;
    adcsr_fifo #(.WIDTH(12), .DEPTH(adcsr_pkg::FIFO_DEPTH)) u_fifo (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_valid(conv_done),
        .o_ready(fifo_ready),
        .i_data(clamped),
        .o_valid(fifo_valid),
        .i_ready(!o_result_valid || i_result_ready),
        .o_data(fifo_data)
    );
    // Output stage register; a word is dropped only when the FIFO is full.
    // It refills whenever empty, so valid never waits for ready
    logic pop;
    assign pop = fifo_valid && (!o_result_valid || i_result_ready);
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_result <= 12'h000;
            o_result_valid <= 1'b0;
        end else if (!o_result_valid || i_result_ready) begin
            o_result_valid <= pop;
            if (pop) begin
                o_result <= fifo_data;
            end
        end
    end
    // Internal shift clock generator
    logic int_run;
    logic [7:0] div_cnt;
    logic [4:0] pulse_cnt;
    logic int_clk;
    logic int_tick;
    logic [11:0] int_shift;
    logic int_tag;
    assign int_tick = int_run && (div_cnt == 8'(adcsr_pkg::SCLK_HALF_CYCLES - 1));
    // first edge about 204 ns after start
    // half period count gives 816 ns
    // 12 pulses then clock parks low
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            int_run <= 1'b0;
            div_cnt <= 8'h00;
            pulse_cnt <= 5'h00;
            int_clk <= 1'b0;
            int_shift <= 12'h000;
            int_tag <= 1'b0;
        end else if (start && !ext_mode) begin
            int_run <= 1'b1;
            div_cnt <= 8'(adcsr_pkg::SCLK_HALF_CYCLES - adcsr_pkg::CLK_START_CYCLES);
            pulse_cnt <= 5'h00;
            int_clk <= 1'b0;
            int_shift <= result;
            int_tag <= tag_s[1];
        end else if (int_tick) begin
            div_cnt <= 8'h00;
            int_clk <= !int_clk;
            if (int_clk) begin
                pulse_cnt <= pulse_cnt + 5'h01;
                int_shift <= {int_shift[10:0], int_tag};
                if (pulse_cnt == 5'(CW - 1)) begin
                    int_run <= 1'b0;
                end
            end
        end else if (int_run) begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
    // External shift: MSB out first, then chain bits from the 12th fall
    logic [11:0] ext_shift;
    logic ext_tag;
    logic ext_en;
    logic ext_active;
    // external output only with select low, convert high
    assign ext_en = ext_mode && !cs_n && conv_n;
    // chain input shifts in on host clock
    // chain level reappears after the word
    // chain bits follow on falling edges
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ext_shift <= 12'h000;
            ext_tag <= 1'b0;
            ext_active <= 1'b0;
        end else if (conv_done) begin
            ext_shift <= clamped;
            ext_active <= 1'b0;
        end else if (ext_en && ext_rise) begin
            if (!ext_active) begin
                ext_active <= 1'b1;
                ext_tag <= tag_s[1];
            end else begin
                ext_tag <= tag_s[1];
            end
        end else if (ext_en && ext_fall && ext_active) begin
            ext_shift <= {ext_shift[10:0], ext_tag};
        end else if (!ext_active) begin
            ext_shift <= result;
        end
    end
    // Registered pin outputs
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_serial_result_out <= 1'b0;
            o_serial_shift_clock <= 1'b0;
            o_serial_shift_clock_oe <= 1'b0;
        end else begin
            o_serial_shift_clock_oe <= !ext_mode;
            o_serial_shift_clock <= int_run && int_clk;
            if (ext_mode) begin
                o_serial_result_out <= ext_shift[11];
            end else begin
                o_serial_result_out <= int_run ? int_shift[11] : int_tag;
            end
        end
    end
endmodule : adcsr_readout

/* File: tb/adcsr_host_model.sv */
// Host model: drives the external shift clock and the chain input.
// Assumes the bench raises i_go once per read; the clock stands still between reads.
`timescale 1ns/1ps
module adcsr_host_model (
    input wire logic i_go,
    input wire logic [7:0] i_n,
    input wire logic [15:0] i_tag,
    input wire logic i_sout,
    output logic o_sclk,
    output logic o_tag,
    output logic [31:0] o_rx,
    output logic o_done
);
    // Idle: clock low, chain line at its first bit
    initial begin
        o_sclk = 1'h0;
        o_tag = 1'h1;
        o_rx = 32'h0;
        o_done = 1'h1;
    end
    // host clocked read
    // 160 ns period, 80 ns phases; chain bit moves after each fall so it is
    // settled long before the rise that captures it
    always @(posedge i_go) begin
        o_done = 1'h0;
        for (int k = 1; k <= i_n; k++) begin
            #80 o_sclk = 1'h1;
            o_rx = {o_rx[30:0], i_sout};
            #80 o_sclk = 1'h0;
            o_tag = i_tag[15 - k];
        end
        o_tag = i_tag[15];
        o_done = 1'h1;
    end
endmodule : adcsr_host_model

/* File: tb/adcsr_readout_checker.sv */
// Checker for the readout block, bound to its ports.
// Assumes one clock domain, i_clk, with async active-low i_rstn.
`timescale 1ns/1ps
module adcsr_readout_checker (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_convert_n,
    input wire logic i_chip_select_n,
    input wire logic i_clock_source_select,
    input wire logic i_chain_in,
    input wire logic o_busy_n,
    input wire logic o_serial_result_out,
    input wire logic o_serial_shift_clock,
    input wire logic o_serial_shift_clock_oe,
    input wire logic [11:0] o_result,
    input wire logic o_result_valid,
    input wire logic i_result_ready
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    logic [11:0] low_cnt;
    // Busy-low length; a counter because the figure is far above any repeat
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) low_cnt <= 12'h000;
        else low_cnt <= o_busy_n ? 12'h000 : low_cnt + 12'h001;
    end
    busy_fall_a: assert property (
        $fell(i_convert_n) && !i_chip_select_n |-> ##[1:5] !o_busy_n)
        else $error("busy did not fall after start");
    busy_length_a: assert property (
        $rose(o_busy_n) |-> low_cnt == 12'(adcsr_pkg::CONV_CYCLES))
        else $error("busy low length wrong");
    start_gate_a: assert property (i_chip_select_n[*6] ##0 o_busy_n |=> o_busy_n)
        else $error("start without chip select");
    clock_idle_a: assert property (o_busy_n |-> !o_serial_shift_clock)
        else $error("shift clock active while idle");
    clock_half_a: assert property (
        $rose(o_serial_shift_clock) |-> ##51 $fell(o_serial_shift_clock))
        else $error("shift clock high phase wrong");
    clock_start_a: assert property (
        $fell(o_busy_n) && o_serial_shift_clock_oe |-> ##[20:28] $rose(o_serial_shift_clock))
        else $error("shift clock start late");
    clock_enable_a: assert property (
        $stable(i_clock_source_select)[*6]
        |-> o_serial_shift_clock_oe == !i_clock_source_select)
        else $error("clock enable disagrees with select");
    chain_tail_a: assert property (
        $rose(o_busy_n) && o_serial_shift_clock_oe
        |-> o_serial_result_out == i_chain_in)
        else $error("serial tail not chain level");
    // Stalled stream word holds
    stream_hold_a: assert property (o_result_valid && !i_result_ready
        |=> o_result_valid && $stable(o_result))
        else $error("stream word dropped while stalled");
    cover property ($rose(o_busy_n));
    cover property ($rose(o_serial_shift_clock));
    cover property (o_result_valid && i_result_ready);
endmodule : adcsr_readout_checker
bind adcsr_readout adcsr_readout_checker u_chk (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_convert_n(i_convert_n), .i_chip_select_n(i_chip_select_n),
    .i_clock_source_select(i_clock_source_select), .i_chain_in(i_chain_in),
    .o_busy_n(o_busy_n), .o_serial_result_out(o_serial_result_out),
    .o_serial_shift_clock(o_serial_shift_clock), .o_serial_shift_clock_oe(o_serial_shift_clock_oe),
    .o_result(o_result), .o_result_valid(o_result_valid), .i_result_ready(i_result_ready));

/* File: tb/adcsr_readout_tb.sv */
// Testbench for the readout block with a host model on the serial side.
// Assumes 125 MHz i_clk; inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module adcsr_readout_tb;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic conv_n = 1'h1;
    logic cs_n = 1'h1;
    logic sel = 1'h1;
    logic rdy = 1'h0;
    logic over = 1'h0;
    logic under = 1'h0;
    logic go = 1'h0;
    logic sq = 1'h0;
    logic [11:0] smp = 12'h000;
    logic [11:0] ibits = 12'h000;
    logic busy_n, sout, sclk_o, oe, vld, done, chain, hclk;
    logic [11:0] res;
    logic [31:0] rx;
    logic [15:0] tagw = 16'h8000;
    int failures = 0, n_checks = 0, cyc = 0, icnt = 0, i0, cnt;
    // Rows: over, under, core code, expected word
    logic [25:0] rows [4] = '{{1'h0, 1'h0, 12'h5a3, 12'h5a3}, {1'h1, 1'h0, 12'h123, 12'h7ff},
        {1'h0, 1'h1, 12'h456, 12'h800}, {1'h0, 1'h0, 12'h800, 12'h800}};
    always #4 clk = ~clk;
    adcsr_readout dut (.i_clk(clk), .i_rstn(rstn), .i_convert_n(conv_n), .i_chip_select_n(cs_n),
        .i_clock_source_select(sel), .i_serial_shift_clock(hclk), .i_chain_in(chain),
        .i_sample(smp), .i_over(over), .i_under(under), .o_busy_n(busy_n),
        .o_serial_result_out(sout), .o_serial_shift_clock(sclk_o),
        .o_serial_shift_clock_oe(oe), .o_result(res), .o_result_valid(vld), .i_result_ready(rdy));
    adcsr_host_model host (.i_go(go), .i_n(8'h0e), .i_tag(tagw), .i_sout(sout), .o_sclk(hclk),
        .o_tag(chain), .o_rx(rx), .o_done(done));
    // Sample generated-clock bits on the core clock to avoid edge races
    always @(posedge clk) begin
        sq <= sclk_o;
        if (sclk_o && !sq) begin
            ibits <= {ibits[10:0], sout};
            icnt <= icnt + 1;
        end
    end
    // Hang guard: the planned run needs about 42000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            test_done();
        end
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // convert pulse of 80 ns with select low
    task conv;
        int w;
        @(posedge clk) #1 conv_n = 1'h0;
        repeat (10) @(posedge clk);
        #1 conv_n = 1'h1;
        chk(busy_n, 1'h0);
        for (w = 0; w < 2000 && busy_n !== 1'h1; w++) @(posedge clk);
        #1 chk(w < adcsr_pkg::CONV_MAX_CYCLES, 1'h1);
    endtask : conv
    task rd;
        go = 1'h1;
        @(posedge clk) #1 go = 1'h0;
        repeat (400) if (done !== 1'h1) @(posedge clk);
        #1;
    endtask : rd
    task pop;
        rdy = 1'h1;
        @(posedge clk) #1 rdy = 1'h0;
    endtask : pop
    task test_done;
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : test_done
    initial begin
        repeat (4) @(posedge clk);
        #1 rstn = 1'h1;
        cs_n = 1'h0;
        repeat (3) @(posedge clk);
        #1;
        // External clock conversions and reads
        for (int r = 0; r < 4; r++) begin
            {over, under, smp} = rows[r][25:12];
            conv();
            chk(res, rows[r][11:0]);
            pop();
            rd();
            chk(rx[13:0], {rows[r][11:0], tagw[15:14]});
        end
        // Internal clock: previous word out during the next conversion
        sel = 1'h0;
        repeat (8) @(posedge clk);
        #1 i0 = icnt;
        conv();
        chk(icnt - i0, 12);
        chk(ibits, 12'h800);
        chk(sout, chain);
        chk(sclk_o, 1'h0);
        pop();
        // Convert pulse with chip select high is ignored
        cs_n = 1'h1;
        repeat (8) @(posedge clk);
        #1 conv_n = 1'h0;
        repeat (10) @(posedge clk);
        #1 conv_n = 1'h1;
        repeat (10) @(posedge clk);
        #1 chk(busy_n, 1'h1);
        cs_n = 1'h0;
        sel = 1'h1;
        // Fill FIFO and output stage past their room, then drain; last word is lost
        for (int k = 0; k < 18; k++) begin
            smp = k[11:0];
            conv();
        end
        cnt = 0;
        rdy = 1'h1;
        for (int j = 0; j < 24; j++) begin
            if (vld === 1'h1) begin
                chk(res, cnt);
                cnt++;
            end
            @(posedge clk) #1;
        end
        rdy = 1'h0;
        // Output stage holds one word beyond the FIFO depth
        chk(cnt, adcsr_pkg::FIFO_DEPTH + 1);
        // Reset in mid-conversion, then recover
        conv_n = 1'h0;
        repeat (50) @(posedge clk);
        #1 rstn = 1'h0;
        conv_n = 1'h1;
        #1 chk({busy_n, sout, sclk_o, oe, vld}, 5'h10);
        repeat (4) @(posedge clk);
        #1 rstn = 1'h1;
        repeat (3) @(posedge clk);
        conv();
        chk(vld, 1'h1);
        chk(res, 12'h011);
        test_done();
    end
endmodule : adcsr_readout_tb
